/* File: hdl/tci_pkg.sv */
// constants shared by the touch reader target and its host controller
// assumes a single 10 MHz system clock on both ends
package tci_pkg;

  // ---------------------------------------------------------------
  // bus addressing and clocking
  // ---------------------------------------------------------------
  localparam logic [6:0]  DEV_ADDR    = 7'h5c;
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned SCL_STD_HZ  = 100_000;
  localparam int unsigned SCL_FAST_HZ = 400_000;
  // quarter bit periods, rounded up so scl never runs above its rate
  localparam logic [4:0]  Q_STD  =
    5'((CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ));
  localparam logic [4:0]  Q_FAST =
    5'((CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ));

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned NUM_FINGERS   = 5;
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_BUTTONS   = 8'h01;
  localparam logic [7:0]  REG_FINGER0   = 8'h02;
  localparam logic [7:0]  FINGER_STRIDE = 8'h05;
  localparam logic [7:0]  OFS_X_LO      = 8'h00;
  localparam logic [7:0]  OFS_X_HI      = 8'h01;
  localparam logic [7:0]  OFS_Y_LO      = 8'h02;
  localparam logic [7:0]  OFS_Y_HI      = 8'h03;
  localparam logic [7:0]  OFS_ID        = 8'h04;
  localparam logic [7:0]  REG_POWER     = 8'h33;
  localparam logic [7:0]  REG_INT_MODE  = 8'h34;
  localparam logic [7:0]  REG_INT_WIDTH = 8'h35;

  // ---------------------------------------------------------------
  // reset values and interrupt pulse timing
  // ---------------------------------------------------------------
  localparam logic [7:0]  POWER_RST     = 8'h00;
  localparam logic [7:0]  INT_MODE_RST  = 8'h01;
  localparam logic [7:0]  INT_WIDTH_RST = 8'h0a;
  localparam int unsigned INT_EN_BIT    = 0;
  localparam int unsigned INT_TICK_US   = 10;
  localparam logic [6:0]  INT_TICK_CYC  =
    7'(INT_TICK_US * (CLK_HZ / 1_000_000));

endpackage : tci_pkg

/* File: hdl/tci_if.sv */
// open-drain two-wire link between the host controller and the target
// assumes the bench resolves nothing else; pull-ups are modelled here
`timescale 1ns/1ns
interface tci_if;
  logic      host_scl_o;
  logic      host_scl_oe_n;
  logic      host_sda_o;
  logic      host_sda_oe_n;
  logic      dev_sda_o;
  logic      dev_sda_oe_n;
  wire logic scl;
  wire logic sda;

  // a line is low when any party enables its low output
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n,
    input  scl,
    input  sda
  );

  modport dev (
    output dev_sda_o,
    output dev_sda_oe_n,
    input  scl,
    input  sda
  );
endinterface : tci_if

/* File: hdl/tci_dev.sv */
// touch panel target: two-wire slave serving a frozen coordinate copy
// assumes scl and sda arrive asynchronous; no clock stretching is done
`timescale 1ns/1ns

// Operation
// - answer only at seven-bit address 0x5c
// - accept both standard and fast scl rates
// - host picks read length, single or sequential
// - host writes pointer, then repeated start read
// - sequential read: status, then finger coordinates
// - status and coordinate reads come from a separate snapshot copy
// - refresh deferred while a read is active
// - stop ends protection and allows refresh
// - host reads all coordinates in one transfer
// - interrupt pulse width set by host write
// - write: pointer first, data stored, autoincrement
// - status low three bits hold finger count
// - coordinates sixteen bits, low byte first
module tci_dev (
  input  wire logic        clk,
  input  wire logic        resetn,
  tci_if.dev               bus,
  input  wire logic        touch_event,
  input  wire logic [2:0]  finger_count_field,
  input  wire logic [4:0]  touch_flags,
  input  wire logic [15:0] pos_x [5],
  input  wire logic [15:0] pos_y [5],
  output logic             int_n,
  output logic [7:0]       power_mode,
  output logic [7:0]       int_mode,
  output logic             read_busy,
  output logic             refresh_pending
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_RACK
  } tci_st_t;
  typedef enum logic [1:0] {PH_ADDR, PH_PTR, PH_DATA} tci_ph_t;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sq;
  logic [1:0] sda_sq;
  logic       scl_p_q;
  logic       sda_p_q;
  logic       scl;
  logic       sda;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;

  // oversampling at 10 MHz keeps fast-rate highs several cycles long
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sq  <= 2'h3;
      sda_sq  <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_sq  <= {scl_sq[0], bus.scl};
      sda_sq  <= {sda_sq[0], bus.sda};
      scl_p_q <= scl_sq[1];
      sda_p_q <= sda_sq[1];
    end
  end

  assign scl   = scl_sq[1];
  assign sda   = sda_sq[1];
  assign rise  = scl & ~scl_p_q;
  assign fall  = ~scl & scl_p_q;
  assign start = scl & scl_p_q & sda_p_q & ~sda;
  assign stop  = scl & scl_p_q & ~sda_p_q & sda;

  // ---------------------------------------------------------------
  // snapshot state
  // ---------------------------------------------------------------
  logic [7:0]  snap_stat_q;
  logic [7:0]  snap_stat_d;
  logic [15:0] snap_x_q [5];
  logic [15:0] snap_x_d [5];
  logic [15:0] snap_y_q [5];
  logic [15:0] snap_y_d [5];
  logic        pend_q;
  logic        pend_d;
  logic        busy_q;

  // ---------------------------------------------------------------
  // serial engine state
  // ---------------------------------------------------------------
  tci_st_t    st_q;
  tci_st_t    st_d;
  tci_ph_t    ph_q;
  tci_ph_t    ph_d;
  logic       rw_q;
  logic       rw_d;
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic [7:0] ptr_q;
  logic [7:0] ptr_d;
  logic       oe_n_q;
  logic       oe_n_d;
  logic       busy_d;
  logic       acked_q;
  logic       acked_d;
  logic [7:0] power_q;
  logic [7:0] power_d;
  logic [7:0] imode_q;
  logic [7:0] imode_d;
  logic [7:0] iwidth_q;
  logic [7:0] iwidth_d;
  logic [7:0] rd_byte;

  // read image seen by the host: status and coordinates from the snapshot, power and interrupt registers live
  always_comb begin
    logic [7:0] fb;
    fb      = tci_pkg::REG_FINGER0;
    rd_byte = 8'h00;
    if (ptr_q == tci_pkg::REG_STATUS) begin
      rd_byte = snap_stat_q;
    end else if (ptr_q == tci_pkg::REG_POWER) begin
      rd_byte = power_q;
    end else if (ptr_q == tci_pkg::REG_INT_MODE) begin
      rd_byte = imode_q;
    end else if (ptr_q == tci_pkg::REG_INT_WIDTH) begin
      rd_byte = iwidth_q;
    end
    for (int i = 0; i < tci_pkg::NUM_FINGERS; i++) begin
      fb = tci_pkg::REG_FINGER0 + 8'(i) * tci_pkg::FINGER_STRIDE;
      if (ptr_q == fb + tci_pkg::OFS_X_LO) begin
        rd_byte = snap_x_q[i][7:0];
      end else if (ptr_q == fb + tci_pkg::OFS_X_HI) begin
        rd_byte = snap_x_q[i][15:8];
      end else if (ptr_q == fb + tci_pkg::OFS_Y_LO) begin
        rd_byte = snap_y_q[i][7:0];
      end else if (ptr_q == fb + tci_pkg::OFS_Y_HI) begin
        rd_byte = snap_y_q[i][15:8];
      end else if (ptr_q == fb + tci_pkg::OFS_ID) begin
        rd_byte = 8'(i + 1);
      end
    end
  end

  always_comb begin
    st_d     = st_q;
    ph_d     = ph_q;
    rw_d     = rw_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    ptr_d    = ptr_q;
    oe_n_d   = oe_n_q;
    busy_d   = busy_q;
    acked_d  = acked_q;
    power_d  = power_q;
    imode_d  = imode_q;
    iwidth_d = iwidth_q;
    if (stop) begin
      st_d   = ST_IDLE;
      oe_n_d = 1'b1;
      busy_d = 1'b0;
    end else if (start) begin
      st_d   = ST_RX;
      ph_d   = PH_ADDR;
      cnt_d  = 4'h0;
      oe_n_d = 1'b1;
    end else begin
      case (st_q)
        ST_RX: begin
          if (rise) begin
            sh_d  = {sh_q[6:0], sda};
            cnt_d = cnt_q + 4'h1;
          end else if (fall && cnt_q == 4'h8) begin
            st_d   = ST_ACK;
            oe_n_d = 1'b0;
            case (ph_q)
              PH_ADDR: begin
                if (sh_q[7:1] == tci_pkg::DEV_ADDR) begin
                  rw_d   = sh_q[0];
                  busy_d = busy_q | sh_q[0];
                end else begin
                  st_d   = ST_IDLE;
                  oe_n_d = 1'b1;
                end
              end
              PH_PTR: ptr_d = sh_q;
              default: begin
                if (ptr_q == tci_pkg::REG_POWER) begin
                  power_d = sh_q;
                end else if (ptr_q == tci_pkg::REG_INT_MODE) begin
                  imode_d = sh_q;
                end else if (ptr_q == tci_pkg::REG_INT_WIDTH) begin
                  iwidth_d = sh_q;
                end
                ptr_d = ptr_q + 8'h01;
              end
            endcase
          end
        end
        ST_ACK: begin
          if (fall) begin
            cnt_d = 4'h0;
            if (ph_q == PH_ADDR && rw_q) begin
              st_d   = ST_TX;
              sh_d   = rd_byte;
              ptr_d  = ptr_q + 8'h01;
              oe_n_d = rd_byte[7];
              cnt_d  = 4'h1;
            end else begin
              st_d   = ST_RX;
              oe_n_d = 1'b1;
              ph_d   = (ph_q == PH_ADDR) ? PH_PTR : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (cnt_q == 4'h8) begin
              st_d   = ST_RACK;
              oe_n_d = 1'b1;
            end else begin
              sh_d   = {sh_q[6:0], 1'b0};
              oe_n_d = sh_q[6];
              cnt_d  = cnt_q + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (rise) begin
            acked_d = ~sda;
          end else if (fall) begin
            if (acked_q) begin
              st_d   = ST_TX;
              sh_d   = rd_byte;
              ptr_d  = ptr_q + 8'h01;
              oe_n_d = rd_byte[7];
              cnt_d  = 4'h1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q     <= ST_IDLE;
      ph_q     <= PH_ADDR;
      rw_q     <= 1'b0;
      cnt_q    <= 4'h0;
      sh_q     <= 8'h00;
      ptr_q    <= 8'h00;
      oe_n_q   <= 1'b1;
      busy_q   <= 1'b0;
      acked_q  <= 1'b0;
      power_q  <= tci_pkg::POWER_RST;
      imode_q  <= tci_pkg::INT_MODE_RST;
      iwidth_q <= tci_pkg::INT_WIDTH_RST;
    end else begin
      st_q     <= st_d;
      ph_q     <= ph_d;
      rw_q     <= rw_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      ptr_q    <= ptr_d;
      oe_n_q   <= oe_n_d;
      busy_q   <= busy_d;
      acked_q  <= acked_d;
      power_q  <= power_d;
      imode_q  <= imode_d;
      iwidth_q <= iwidth_d;
    end
  end

  // ---------------------------------------------------------------
  // snapshot refresh
  // ---------------------------------------------------------------
  // a new event during the copy keeps the request pending
  always_comb begin
    snap_stat_d = snap_stat_q;
    snap_x_d    = snap_x_q;
    snap_y_d    = snap_y_q;
    pend_d      = touch_event | (pend_q & busy_q);
    if (pend_q && !busy_q) begin
      snap_stat_d = {touch_flags, finger_count_field};
      snap_x_d    = pos_x;
      snap_y_d    = pos_y;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      snap_stat_q <= 8'h00;
      snap_x_q    <= '{default: 16'h0000};
      snap_y_q    <= '{default: 16'h0000};
      pend_q      <= 1'b0;
    end else begin
      snap_stat_q <= snap_stat_d;
      snap_x_q    <= snap_x_d;
      snap_y_q    <= snap_y_d;
      pend_q      <= pend_d;
    end
  end

  // ---------------------------------------------------------------
  // interrupt pulse
  // ---------------------------------------------------------------
  logic [6:0] tick_q;
  logic [6:0] tick_d;
  logic [7:0] icnt_q;
  logic [7:0] icnt_d;
  logic       int_n_q;
  logic       int_n_d;

  // width is counted in ticks; zero is treated as one tick
  always_comb begin
    tick_d = (tick_q == tci_pkg::INT_TICK_CYC - 7'h01) ? 7'h00
                                                       : tick_q + 7'h01;
    icnt_d = icnt_q;
    if (touch_event && imode_q[tci_pkg::INT_EN_BIT]) begin
      icnt_d = (iwidth_q == 8'h00) ? 8'h01 : iwidth_q;
      tick_d = 7'h00;
    end else if (tick_q == tci_pkg::INT_TICK_CYC - 7'h01 &&
                 icnt_q != 8'h00) begin
      icnt_d = icnt_q - 8'h01;
    end
    int_n_d = (icnt_d == 8'h00);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tick_q  <= 7'h00;
      icnt_q  <= 8'h00;
      int_n_q <= 1'b1;
    end else begin
      tick_q  <= tick_d;
      icnt_q  <= icnt_d;
      int_n_q <= int_n_d;
    end
  end

  assign bus.dev_sda_o    = 1'b0;
  assign bus.dev_sda_oe_n = oe_n_q;
  assign int_n            = int_n_q;
  assign power_mode       = power_q;
  assign int_mode         = imode_q;
  assign read_busy        = busy_q;
  assign refresh_pending  = pend_q;

endmodule : tci_dev

/* File: hdl/tci_host.sv */
// host controller: writes the pointer, then writes or reads registers
// assumes the target answers at the fixed address and never stretches
`timescale 1ns/1ns
module tci_host (
  input  wire logic       clk,
  input  wire logic       resetn,
  tci_if.host             bus,
  input  wire logic       fast_mode,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [7:0] cmd_wdata,
  input  wire logic [5:0] cmd_len,
  output logic            rd_valid,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nack_err
);

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} tci_hs_t;
  typedef enum logic [2:0] {P_AW, P_REG, P_DATA, P_AR, P_RD} tci_hp_t;

  // ---------------------------------------------------------------
  // sda synchroniser
  // ---------------------------------------------------------------
  logic [1:0] sda_sq;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_sq <= 2'h3;
    end else begin
      sda_sq <= {sda_sq[0], bus.sda};
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  tci_hs_t    hs_q, hs_d;
  tci_hp_t    hp_q, hp_d;
  logic [4:0] div_q, div_d;
  logic [1:0] q_q, q_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] sh_q, sh_d;
  logic [5:0] cnt_q, cnt_d;
  logic [5:0] len_q, len_d;
  logic       wr_q, wr_d;
  logic [7:0] reg_q, reg_d;
  logic [7:0] wd_q, wd_d;
  logic       scl_oe_n_q, scl_oe_n_d;
  logic       sda_oe_n_q, sda_oe_n_d;
  logic       ack_q, ack_d;
  logic       rdv_q, rdv_d;
  logic [7:0] rdd_q, rdd_d;
  logic       done_q, done_d;
  logic       err_q, err_d;
  logic       qtick;

  assign qtick = (hs_q != H_IDLE) && (div_q == 5'h00);

  always_comb begin
    hs_d  = hs_q;
    hp_d  = hp_q;
    q_d   = q_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    cnt_d = cnt_q;
    len_d = len_q;
    wr_d  = wr_q;
    reg_d = reg_q;
    wd_d  = wd_q;
    ack_d = ack_q;
    rdd_d = rdd_q;
    scl_oe_n_d = scl_oe_n_q;
    sda_oe_n_d = sda_oe_n_q;
    err_d  = err_q;
    rdv_d  = 1'b0;
    done_d = 1'b0;
    div_d  = (div_q == 5'h00) ? (fast_mode ? tci_pkg::Q_FAST
                                           : tci_pkg::Q_STD) - 5'h01
                              : div_q - 5'h01;
    if (hs_q == H_IDLE) begin
      div_d = 5'h00;
      if (cmd_valid) begin
        hs_d  = H_START;
        hp_d  = P_AW;
        q_d   = 2'h0;
        wr_d  = cmd_write;
        reg_d = cmd_reg;
        wd_d  = cmd_wdata;
        len_d = cmd_len;
        err_d = 1'b0;
      end
    end else if (qtick) begin
      q_d = q_q + 2'h1;
      case (hs_q)
        H_START: begin
          case (q_q)
            2'h0: sda_oe_n_d = 1'b1;
            2'h1: scl_oe_n_d = 1'b1;
            2'h2: sda_oe_n_d = 1'b0;
            default: begin
              scl_oe_n_d = 1'b0;
              hs_d  = H_BIT;
              bit_d = 4'h0;
              sh_d  = {tci_pkg::DEV_ADDR, hp_q == P_AR};
            end
          endcase
        end
        H_BIT: begin
          case (q_q)
            2'h0: begin
              if (hp_q != P_RD) begin
                sda_oe_n_d = (bit_q == 4'h8) | sh_q[7];
              end else begin
                // last byte is left unacknowledged
                sda_oe_n_d = (bit_q != 4'h8) |
                             (cnt_q == len_q - 6'h01);
              end
            end
            2'h1: scl_oe_n_d = 1'b1;
            2'h2: begin
              if (bit_q == 4'h8) ack_d = ~sda_sq[1];
              else sh_d = {sh_q[6:0], sda_sq[1]};
            end
            default: begin
              scl_oe_n_d = 1'b0;
              bit_d = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_d = 4'h0;
                if (hp_q != P_RD && !ack_q) begin
                  err_d = 1'b1;
                  hs_d  = H_STOP;
                end else begin
                  case (hp_q)
                    P_AW: begin
                      hp_d = P_REG;
                      sh_d = reg_q;
                    end
                    P_REG: begin
                      if (wr_q) begin
                        hp_d = P_DATA;
                        sh_d = wd_q;
                      end else if (len_q == 6'h00) begin
                        hs_d = H_STOP;
                      end else begin
                        hs_d = H_START;
                        hp_d = P_AR;
                      end
                    end
                    P_AR: begin
                      hp_d  = P_RD;
                      cnt_d = 6'h00;
                    end
                    P_RD: begin
                      rdv_d = 1'b1;
                      rdd_d = sh_q;
                      cnt_d = cnt_q + 6'h01;
                      if (cnt_q == len_q - 6'h01) hs_d = H_STOP;
                    end
                    default: hs_d = H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (q_q)
            2'h0: sda_oe_n_d = 1'b0;
            2'h1: scl_oe_n_d = 1'b1;
            2'h2: sda_oe_n_d = 1'b1;
            default: begin
              hs_d   = H_IDLE;
              done_d = 1'b1;
            end
          endcase
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hs_q  <= H_IDLE;
      hp_q  <= P_AW;
      div_q <= 5'h00;
      q_q   <= 2'h0;
      bit_q <= 4'h0;
      sh_q  <= 8'h00;
      cnt_q <= 6'h00;
      len_q <= 6'h00;
      wr_q  <= 1'b0;
      reg_q <= 8'h00;
      wd_q  <= 8'h00;
      ack_q <= 1'b0;
      scl_oe_n_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      rdv_q  <= 1'b0;
      rdd_q  <= 8'h00;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else begin
      hs_q  <= hs_d;
      hp_q  <= hp_d;
      div_q <= div_d;
      q_q   <= q_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      cnt_q <= cnt_d;
      len_q <= len_d;
      wr_q  <= wr_d;
      reg_q <= reg_d;
      wd_q  <= wd_d;
      ack_q <= ack_d;
      scl_oe_n_q <= scl_oe_n_d;
      sda_oe_n_q <= sda_oe_n_d;
      rdv_q  <= rdv_d;
      rdd_q  <= rdd_d;
      done_q <= done_d;
      err_q  <= err_d;
    end
  end

  assign bus.host_scl_o    = 1'b0;
  assign bus.host_sda_o    = 1'b0;
  assign bus.host_scl_oe_n = scl_oe_n_q;
  assign bus.host_sda_oe_n = sda_oe_n_q;
  assign cmd_ready         = (hs_q == H_IDLE);
  assign rd_valid          = rdv_q;
  assign rd_data           = rdd_q;
  assign done              = done_q;
  assign nack_err          = err_q;

endmodule : tci_host

/* File: verification/tci_link_sva.sv */
// wire-level checks on the two-wire link between host and target
// assumes the bench hands in the interface lines and the system clock
`timescale 1ns/1ns
module tci_link_sva (
  input wire logic clk,
  input wire logic resetn,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // clock shape and framing
  // ----------------------------------------------------------------
  a_scl_high_min: assert property ($rose(scl) |-> scl[*8])
    else $error("scl high phase too short");
  a_scl_low_min: assert property ($fell(scl) |-> !scl[*8])
    else $error("scl low phase too short");
  a_start_hold: assert property (scl && $fell(host_sda_oe_n) |-> scl[*4])
    else $error("start not held");
  a_stop_setup: assert property (scl && $rose(host_sda_oe_n) |-> $past(scl, 4))
    else $error("stop setup too short");

  // ----------------------------------------------------------------
  // target drive
  // ----------------------------------------------------------------
  // target may only move sda while scl is low, else it fakes start/stop
  a_dev_pull_low: assert property ($fell(dev_sda_oe_n) |-> !scl)
    else $error("target pulled sda with scl high");
  a_dev_rel_low: assert property ($rose(dev_sda_oe_n) |-> !scl)
    else $error("target released sda with scl high");
  a_dev_drive_bound: assert property ($fell(dev_sda_oe_n) |-> ##[1:1000] dev_sda_oe_n)
    else $error("target holds sda too long");
  a_stop_bus_free: assert property (scl && $rose(sda) |=> dev_sda_oe_n[*8])
    else $error("target drives after stop");

  c_start: cover property (scl && $fell(sda));
  c_dev_ack: cover property ($fell(dev_sda_oe_n));
  c_stop: cover property (scl && $rose(sda));
endmodule : tci_link_sva

/* File: verification/touch_i2c_snapshot_reader_bench.sv */
// bench: host and target face each other over the two-wire link
// assumes a 10 MHz clk; inputs change at falling edges
`timescale 1ns/1ns
module touch_i2c_snapshot_reader_bench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        touch_event = 1'b0;
  logic        fast_mode = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [7:0]  cmd_reg = 8'h00;
  logic [7:0]  cmd_wdata = 8'h00;
  logic [5:0]  cmd_len = 6'h00;
  logic [2:0]  cnt = 3'h0;
  logic [4:0]  flg = 5'h00;
  logic [15:0] px [5];
  logic [15:0] py [5];
  logic [15:0] ex [5];
  logic [15:0] ey [5];
  logic [7:0]  es, pw, rd_data, power_mode, int_mode;
  logic        int_n, read_busy, refresh_pending, cmd_ready;
  logic        rd_valid, done, nack_err;
  logic [7:0]  got [$];
  int          num_errors = 0;
  int          checked = 0;
  int          cycles = 0;

  always #50 clk = ~clk;

  tci_if u_tci_if ();
  tci_dev u_tci_dev (.clk(clk), .resetn(resetn), .bus(u_tci_if.dev),
    .touch_event(touch_event), .finger_count_field(cnt),
    .touch_flags(flg), .pos_x(px), .pos_y(py), .int_n(int_n),
    .power_mode(power_mode), .int_mode(int_mode),
    .read_busy(read_busy), .refresh_pending(refresh_pending));
  tci_host u_tci_host (.clk(clk), .resetn(resetn), .bus(u_tci_if.host),
    .fast_mode(fast_mode), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_write(cmd_write), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
    .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_data(rd_data),
    .done(done), .nack_err(nack_err));
  tci_link_sva u_tci_link_sva (.clk(clk), .resetn(resetn),
    .host_sda_oe_n(u_tci_if.host_sda_oe_n),
    .dev_sda_oe_n(u_tci_if.dev_sda_oe_n),
    .scl(u_tci_if.scl), .sda(u_tci_if.sda));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
                     input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk

  function automatic logic [7:0] eb(input int a);
    int          o;
    logic [15:0] v;
    o = (a - 2) % 5;
    if (a == 0) return es;
    if (a < 2 || a > 26) return 8'h00;
    v = (o < 2) ? ex[(a - 2) / 5] : ey[(a - 2) / 5];
    if (o == 4) return 8'((a - 2) / 5 + 1);
    return (o % 2 == 0) ? v[7:0] : v[15:8];
  endfunction : eb

  task automatic xfer(input logic w, input logic [7:0] r,
                      input logic [7:0] d, input logic [5:0] n);
    int k;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_reg = r;
    cmd_wdata = d;
    cmd_len = n;
    @(negedge clk);
    cmd_valid = 1'b0;
    got.delete();
    for (k = 0; k < 40000 && done !== 1'b1; k++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end
    chk({done, cmd_ready}, 8'h03, "done and ready");
    chk(nack_err, 1'b0, "target nack");
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [5:0] n);
    xfer(1'b0, a, 8'h00, n);
    chk(8'(got.size()), {2'b00, n}, "length");
    foreach (got[k]) chk(got[k], eb(a + k), "read byte");
  endtask : rd

  // new random report, latched by the target a cycle after the pulse, or after stop during a read
  task automatic touch();
    @(negedge clk);
    foreach (px[i]) begin
      px[i] = 16'($urandom);
      py[i] = 16'($urandom);
    end
    cnt = 3'($urandom_range(5));
    flg = 5'($urandom);
    touch_event = 1'b1;
    @(negedge clk);
    touch_event = 1'b0;
  endtask : touch

  task automatic snap();
    ex = px;
    ey = py;
    es = {flg, cnt};
  endtask : snap

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(38288));
    foreach (px[i]) begin
      px[i] = 16'h0000;
      py[i] = 16'h0000;
    end
    repeat (8) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    chk(int_n, 1'b1, "int idle");
    chk(int_mode, tci_pkg::INT_MODE_RST, "int mode reset");
    chk(power_mode, tci_pkg::POWER_RST, "power reset");
    $display("test reset done");
    pw = 8'($urandom);
    xfer(1'b1, tci_pkg::REG_POWER, pw, 6'h00);
    chk(power_mode, pw, "power write");
    xfer(1'b1, tci_pkg::REG_INT_WIDTH, 8'h01, 6'h00);
    touch();
    repeat (50) @(negedge clk);
    chk(int_n, 1'b0, "int pulse");
    repeat (60) @(negedge clk);
    chk(int_n, 1'b1, "int width");
    snap();
    xfer(1'b0, tci_pkg::REG_POWER, 8'h00, 6'h03);
    chk(got[0], pw, "power read");
    chk(got[1], tci_pkg::INT_MODE_RST, "mode read");
    chk(got[2], 8'h01, "width read");
    $display("test config done");
    fast_mode = 1'b1;
    fork
      rd(8'h00, 6'd27);
      begin
        wait (read_busy === 1'b1);
        touch();
        repeat (3) @(negedge clk);
        chk(refresh_pending, 1'b1, "refresh held");
      end
    join
    repeat (5) @(negedge clk);
    chk(refresh_pending, 1'b0, "refresh after stop");
    chk(read_busy, 1'b0, "busy after stop");
    snap();
    rd(8'h00, 6'd27);
    $display("test snapshot done");
    fast_mode = 1'b0;
    rd(8'(2 + $urandom_range(24)), 6'd1);
    rd(8'h1a, 6'd2);
    $display("test single done");
    print_verdict();
  end
endmodule : touch_i2c_snapshot_reader_bench
